//--- sacc_cfg.svh
// Constants of the converter control block: reset values, field codes, counts.
// Included by the package, the formatter, the top module and the bench; definitions only.
`ifndef SACC_CFG_SVH
`define SACC_CFG_SVH
`define SACC_NEG_GND       5'h1F
`define SACC_NEG_VREF      5'h1E
`define SACC_POS_TEMP      5'h1E
`define SACC_POS_SUPPLY    5'h1F
`define SACC_SEL_COUNT     25
`define SACC_DIV_RESET     5'h1F
`define SACC_RESULT_BITS   10
`define SACC_TRACK_CLOCKS  4'h3
`define SACC_MODE_SW       3'h0
`define SACC_MODE_T0       3'h1
`define SACC_MODE_T2       3'h2
`define SACC_MODE_T1       3'h3
`define SACC_MODE_PIN      3'h4
`define SACC_MODE_T3       3'h5
`endif

//--- sacc_clkdiv.sv
// Conversion clock divider: one-cycle tick every div+1 system clocks.
// Assumes div is held stable while enabled.
`timescale 1ns/1ps
module sacc_clkdiv (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Control
  input  wire logic       run,
  input  wire logic [4:0] div,
  // Tick out
  output logic            tick
);
  typedef struct packed {
    logic [4:0] count;
    logic       tick;
  } sacc_div_s;
  sacc_div_s st;
  sacc_div_s next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run) begin
      next_st.count = 5'h00;
    end else if (st.count >= div) begin
      next_st.count = 5'h00;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;

  tick_period_a: assert property (@(posedge clk) disable iff (rst)
    tick && div != 5'h00
    |=> !tick)
    else $error("divider tick repeated on consecutive cycles");
endmodule

//--- sacc_format.sv
// Result formatter: justification and sign fill of a 10-bit code.
// Pure combinational; caller registers the result.
`timescale 1ns/1ps
`include "sacc_cfg.svh"
module sacc_format (
  // Raw code and format
  input  wire logic [9:0]         code,
  input  wire logic               differential,
  input  wire logic               left_justify,
  // Formatted word
  output sacc_pkg::sacc_result_s  result
);
  always_comb begin
    if (left_justify) begin
      result = {code, 6'h00};
    end else if (differential) begin
      result = {{6{code[9]}}, code};
    end else begin
      result = {6'h00, code};
    end
  end
endmodule

//--- sacc_pkg.sv
// Types shared by the converter control modules.
// Assumes sacc_cfg.svh sits in the include path.
`include "sacc_cfg.svh"
package sacc_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_TRACK, ST_CONVERT} sacc_state_e;
  typedef struct packed {
    logic [4:0] pos_sel;
    logic [4:0] neg_sel;
    logic [4:0] div;
    logic       left_justify;
    logic [2:0] start_mode;
    logic       low_power_track;
    logic       enable;
  } sacc_cfg_s;
  typedef struct packed {
    logic [7:0] high_byte;
    logic [7:0] low_byte;
  } sacc_result_s;
endpackage

//--- sacc_timer_model.sv
// Far-side model: timer overflow pulses and the analog comparator.
// Assumes fire is held for exactly one clock by the bench.
`timescale 1ns/1ps
module sacc_timer_model (
  // Bench commands
  input  wire logic       fire,
  input  wire logic [2:0] src,
  input  wire logic [9:0] target,
  // From the block
  input  wire logic [9:0] dac_code,
  // Toward the block
  output logic      [5:0] ovf,
  output logic            comparator_high
);
  // One overflow line per source: t0, t1, t2 low, t2 high, t3 low, t3 high
  assign ovf = fire ? (6'h01 << src) : 6'h00;
  // Input held still, so the search must settle on target
  assign comparator_high = (dac_code <= target);
endmodule

//--- sacc_top.sv
// Conversion control for a 10-bit successive-approximation converter.
// Assumes timer overflow pulses are on clk; start pin and comparator are asynchronous.
`timescale 1ns/1ps
`include "sacc_cfg.svh"
module sacc_top #(
  parameter int RESULT_BITS = `SACC_RESULT_BITS
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Configuration
  input  wire sacc_pkg::sacc_cfg_s   cfg,
  // Software start, flag clear and interrupt enable
  input  wire logic                  sw_start,
  input  wire logic                  complete_clear,
  input  wire logic                  irq_enable,
  // Start sources
  input  wire logic                  timer0_overflow,
  input  wire logic                  timer1_overflow,
  input  wire logic                  timer2_low_overflow,
  input  wire logic                  timer2_high_overflow,
  input  wire logic                  timer2_split_8bit,
  input  wire logic                  timer3_low_overflow,
  input  wire logic                  timer3_high_overflow,
  input  wire logic                  timer3_split_8bit,
  input  wire logic                  external_start_pin,
  // Analog front end
  input  wire logic                  comparator_high,
  output logic                       analog_power_on,
  output logic                       track_enable,
  output logic [4:0]                 positive_input_select,
  output logic [4:0]                 negative_input_select,
  output logic                       differential_mode,
  output logic [RESULT_BITS-1:0]     dac_code,
  // Status and result
  output logic                       conversion_busy_bit,
  output logic                       conversion_complete_flag,
  output logic                       converter_irq,
  output logic [7:0]                 result_high_byte,
  output logic [7:0]                 result_low_byte
);
  typedef struct packed {
    sacc_pkg::sacc_state_e  state;
    logic [2:0]             pin_sync;
    logic                   pin_level;
    logic [2:0]             cmp_sync;
    logic                   cmp_level;
    logic [3:0]             track_count;
    logic [3:0]             bit_index;
    logic [RESULT_BITS-1:0] sar;
    logic                   busy;
    logic                   busy_last;
    logic                   complete;
    sacc_pkg::sacc_result_s result;
  } sacc_top_s;

  sacc_top_s              st;
  sacc_top_s              next_st;
  logic                   conv_tick;
  logic                   div_run;
  logic                   single_ended;
  logic                   pin_rise;
  logic                   trigger;
  logic                   cmp_now;
  logic                   track_first;
  logic [RESULT_BITS-1:0] trial;
  sacc_pkg::sacc_result_s formatted;

  assign single_ended = (cfg.neg_sel == `SACC_NEG_GND);
  assign div_run = cfg.enable && (st.state != sacc_pkg::ST_IDLE);

  sacc_clkdiv u_div (
    .clk  (clk),
    .rst  (rst),
    .run  (div_run),
    .div  (cfg.div),
    .tick (conv_tick)
  );

  // Pin edge only seen once second and third stages agree
  assign pin_rise = (st.pin_sync[2:1] == 2'b11) && !st.pin_level;

  // Comparator bit counts once the last two stages agree, saving a cycle per bit
  assign cmp_now = (st.cmp_sync[2] == st.cmp_sync[1]) ? st.cmp_sync[2] : st.cmp_level;
  // Pin start in low-power mode converts at once: the pin's low phase was the tracking
  assign track_first = cfg.low_power_track && (cfg.start_mode != `SACC_MODE_PIN);

  always_comb begin
    trigger = 1'b0;
    case (cfg.start_mode)
      `SACC_MODE_SW:  trigger = sw_start;
      `SACC_MODE_T0:  trigger = timer0_overflow;
      `SACC_MODE_T1:  trigger = timer1_overflow;
      `SACC_MODE_T2:  trigger = timer2_split_8bit ? timer2_low_overflow : timer2_high_overflow;
      `SACC_MODE_T3:  trigger = timer3_split_8bit ? timer3_low_overflow : timer3_high_overflow;
      `SACC_MODE_PIN: trigger = pin_rise;
      default:        trigger = 1'b0;
    endcase
  end

  // Current trial bit set on top of bits already resolved
  always_comb begin
    trial = st.sar;
    trial[st.bit_index] = 1'b1;
  end

  sacc_format u_fmt (
    .code         (st.sar),
    .differential (!single_ended),
    .left_justify (cfg.left_justify),
    .result       (formatted)
  );

  always_comb begin
    next_st = st;
    next_st.pin_sync = {st.pin_sync[1:0], external_start_pin};
    if (st.pin_sync[2] == st.pin_sync[1]) begin
      next_st.pin_level = st.pin_sync[2];
    end
    next_st.cmp_sync = {st.cmp_sync[1:0], comparator_high};
    if (st.cmp_sync[2] == st.cmp_sync[1]) begin
      next_st.cmp_level = st.cmp_sync[2];
    end
    next_st.busy_last = st.busy;
    // Set beats clear when both land together
    if (complete_clear) begin
      next_st.complete = 1'b0;
    end
    if (st.busy_last && !st.busy) begin
      next_st.complete = 1'b1;
    end
    if (!cfg.enable) begin
      next_st.state = sacc_pkg::ST_IDLE;
      next_st.busy = 1'b0;
    end else begin
      case (st.state)
        sacc_pkg::ST_IDLE: begin
          if (trigger) begin
            next_st.busy = 1'b1;
            next_st.sar = '0;
            next_st.bit_index = 4'(RESULT_BITS - 1);
            next_st.track_count = 4'h0;
            next_st.state = track_first ? sacc_pkg::ST_TRACK : sacc_pkg::ST_CONVERT;
          end
        end
        sacc_pkg::ST_TRACK: begin
          if (conv_tick) begin
            if (st.track_count == `SACC_TRACK_CLOCKS - 4'h1) begin
              next_st.state = sacc_pkg::ST_CONVERT;
            end else begin
              next_st.track_count = st.track_count + 4'h1;
            end
          end
        end
        sacc_pkg::ST_CONVERT: begin
          // Further triggers fall here and are dropped
          if (conv_tick) begin
            next_st.sar[st.bit_index] = cmp_now;
            if (st.bit_index == 4'h0) begin
              next_st.state = sacc_pkg::ST_IDLE;
              next_st.busy = 1'b0;
            end else begin
              next_st.bit_index = st.bit_index - 4'h1;
            end
          end
        end
        default: next_st.state = sacc_pkg::ST_IDLE;
      endcase
    end
    // Result latched one clock after busy falls
    if (st.busy_last && !st.busy) begin
      next_st.result = formatted;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign analog_power_on = cfg.enable;
  // Pin start in low-power mode tracks while pin low
  always_comb begin
    if (!cfg.enable) begin
      track_enable = 1'b0;
    end else if (cfg.low_power_track && cfg.start_mode == `SACC_MODE_PIN) begin
      track_enable = (st.state == sacc_pkg::ST_IDLE) ? !st.pin_level : (st.state == sacc_pkg::ST_TRACK);
    end else if (cfg.low_power_track) begin
      track_enable = (st.state == sacc_pkg::ST_TRACK);
    end else begin
      track_enable = (st.state != sacc_pkg::ST_CONVERT);
    end
  end
  assign positive_input_select = cfg.pos_sel;
  assign negative_input_select = cfg.neg_sel;
  assign differential_mode = !single_ended;
  assign dac_code = (st.state == sacc_pkg::ST_CONVERT) ? trial : st.sar;
  assign conversion_busy_bit = st.busy;
  assign conversion_complete_flag = st.complete;
  assign converter_irq = st.complete && irq_enable;
  assign result_high_byte = st.result.high_byte;
  assign result_low_byte = st.result.low_byte;

  // Enable, start and sequencing checks
  off_idle_a: assert property (@(posedge clk) disable iff (rst)
    !cfg.enable
    |=> !conversion_busy_bit)
    else $error("busy while disabled");

  start_busy_a: assert property (@(posedge clk) disable iff (rst)
    cfg.enable && st.state == sacc_pkg::ST_IDLE && trigger
    |=> conversion_busy_bit)
    else $error("start did not raise busy");

  busy_hold_a: assert property (@(posedge clk) disable iff (rst)
    cfg.enable && conversion_busy_bit
    && !(st.state == sacc_pkg::ST_CONVERT && conv_tick && st.bit_index == 4'h0)
    |=> conversion_busy_bit)
    else $error("busy dropped before the last bit");

  ignore_start_a: assert property (@(posedge clk) disable iff (rst)
    st.state == sacc_pkg::ST_CONVERT && !conv_tick && cfg.enable
    |=> st.state == sacc_pkg::ST_CONVERT)
    else $error("conversion disturbed");

  bit_order_a: assert property (@(posedge clk) disable iff (rst)
    cfg.enable && st.state == sacc_pkg::ST_CONVERT && conv_tick && st.bit_index != 4'h0
    |=> st.bit_index == $past(st.bit_index) - 4'h1)
    else $error("result bits not resolved msb first");

  track_len_a: assert property (@(posedge clk) disable iff (rst)
    $rose(st.state == sacc_pkg::ST_TRACK)
    |-> st.track_count == 4'h0)
    else $error("tracking count not restarted");

  track_exit_a: assert property (@(posedge clk) disable iff (rst)
    cfg.enable && st.state == sacc_pkg::ST_TRACK && conv_tick
    && st.track_count == `SACC_TRACK_CLOCKS - 4'h1
    |=> st.state == sacc_pkg::ST_CONVERT)
    else $error("tracking did not end after three clocks");

  pin_direct_a: assert property (@(posedge clk) disable iff (rst)
    cfg.enable && cfg.low_power_track && cfg.start_mode == `SACC_MODE_PIN
    && st.state == sacc_pkg::ST_IDLE && trigger
    |=> st.state == sacc_pkg::ST_CONVERT)
    else $error("pin start tracked again after its edge");

  t2_half_a: assert property (@(posedge clk) disable iff (rst)
    cfg.enable && st.state == sacc_pkg::ST_IDLE && cfg.start_mode == `SACC_MODE_T2
    && timer2_split_8bit && !timer2_low_overflow
    |=> !conversion_busy_bit)
    else $error("8-bit timer 2 started without low overflow");

  t3_half_a: assert property (@(posedge clk) disable iff (rst)
    cfg.enable && st.state == sacc_pkg::ST_IDLE && cfg.start_mode == `SACC_MODE_T3
    && !timer3_split_8bit && !timer3_high_overflow
    |=> !conversion_busy_bit)
    else $error("16-bit timer 3 started without high overflow");

  // Mode and tracking checks
  mode_select_a: assert property (@(posedge clk) disable iff (rst)
    (cfg.neg_sel == 5'h1F)
    |-> !differential_mode)
    else $error("ground negative not single-ended");

  cont_track_a: assert property (@(posedge clk) disable iff (rst)
    cfg.enable && !cfg.low_power_track && st.state == sacc_pkg::ST_CONVERT
    |-> !track_enable)
    else $error("tracking during conversion");

  lp_idle_a: assert property (@(posedge clk) disable iff (rst)
    cfg.enable && cfg.low_power_track && cfg.start_mode != `SACC_MODE_PIN
    && st.state != sacc_pkg::ST_TRACK
    |-> !track_enable)
    else $error("low-power tracking outside its window");

  // Result format checks
  result_load_a: assert property (@(posedge clk) disable iff (rst)
    $fell(conversion_busy_bit) && !cfg.left_justify && single_ended && $stable(cfg)
    |=> result_high_byte[7:2] == 6'h00)
    else $error("unused result bits not zero");

  result_lj_a: assert property (@(posedge clk) disable iff (rst)
    $fell(conversion_busy_bit) && cfg.left_justify && $stable(cfg)
    |=> result_low_byte[5:0] == 6'h00)
    else $error("left-justified low bits not zero");

  result_sign_a: assert property (@(posedge clk) disable iff (rst)
    $fell(conversion_busy_bit) && !cfg.left_justify && !single_ended && $stable(cfg)
    |=> result_high_byte[7:2] == {6{result_high_byte[1]}})
    else $error("sign fill wrong");

  result_code_a: assert property (@(posedge clk) disable iff (rst)
    $fell(conversion_busy_bit) && !cfg.left_justify && $stable(cfg)
    |=> {result_high_byte[1:0], result_low_byte} == $past(st.sar))
    else $error("right-justified code not loaded");

  result_left_a: assert property (@(posedge clk) disable iff (rst)
    $fell(conversion_busy_bit) && cfg.left_justify && $stable(cfg)
    |=> {result_high_byte, result_low_byte[7:6]} == $past(st.sar))
    else $error("left-justified code not loaded");

  // Flag and interrupt checks
  busy_fall_a: assert property (@(posedge clk) disable iff (rst)
    $fell(conversion_busy_bit)
    |=> conversion_complete_flag)
    else $error("complete flag not set after busy fell");

  clear_flag_a: assert property (@(posedge clk) disable iff (rst)
    complete_clear && !(st.busy_last && !st.busy)
    |=> !conversion_complete_flag)
    else $error("complete flag not cleared");

  irq_gate_a: assert property (@(posedge clk) disable iff (rst)
    $fell(conversion_busy_bit)
    |=> converter_irq == irq_enable)
    else $error("interrupt not raised at completion");

  // Main scenarios
  cover_sw_c: cover property (@(posedge clk) cfg.start_mode == 3'h0 && $fell(conversion_busy_bit));
  cover_pin_c: cover property (@(posedge clk) cfg.low_power_track && pin_rise && st.state == sacc_pkg::ST_IDLE);
  cover_diff_c: cover property (@(posedge clk) differential_mode && $fell(conversion_busy_bit));
  cover_track_c: cover property (@(posedge clk) $fell(st.state == sacc_pkg::ST_TRACK));
  cover_abort_c: cover property (@(posedge clk) conversion_busy_bit && !cfg.enable);
endmodule

//--- sacc_top_test.sv
// Self-checking bench for the converter control block.
// Assumes sacc_cfg.svh in the include path; divider kept at 3 or more.
`timescale 1ns/1ps
`include "sacc_cfg.svh"
module sacc_top_test;
  logic                clk = 1'b0;
  logic                rst = 1'b1;
  sacc_pkg::sacc_cfg_s cfg = '0;
  logic sw_start = 1'b0, complete_clear = 1'b0, irq_enable = 1'b1, split2 = 1'b0, split3 = 1'b0;
  logic pin = 1'b0, fire = 1'b0;
  logic [2:0] src = 3'h0;
  logic [9:0] target = 10'h000;
  logic [5:0] ovf;
  logic       cmp_high, power_on, track_en, diff, busy, flag, irq;
  logic [4:0] pos_out, neg_out;
  logic [9:0] dac;
  logic [7:0] res_hi, res_lo;
  int n_mismatch = 0;
  int samples_checked = 0;

  always #12.5 clk = ~clk;

  sacc_timer_model i_sacc_timer_model (.fire(fire), .src(src), .target(target), .dac_code(dac), .ovf(ovf),
    .comparator_high(cmp_high));

  sacc_top i_sacc_top (.clk(clk), .rst(rst), .cfg(cfg), .sw_start(sw_start), .complete_clear(complete_clear),
    .irq_enable(irq_enable), .timer0_overflow(ovf[0]), .timer1_overflow(ovf[1]), .timer2_low_overflow(ovf[2]),
    .timer2_high_overflow(ovf[3]), .timer2_split_8bit(split2), .timer3_low_overflow(ovf[4]),
    .timer3_high_overflow(ovf[5]), .timer3_split_8bit(split3), .external_start_pin(pin),
    .comparator_high(cmp_high), .analog_power_on(power_on), .track_enable(track_en),
    .positive_input_select(pos_out), .negative_input_select(neg_out), .differential_mode(diff),
    .dac_code(dac), .conversion_busy_bit(busy), .conversion_complete_flag(flag), .converter_irq(irq),
    .result_high_byte(res_hi), .result_low_byte(res_lo));

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk16({15'h0000, got}, {15'h0000, exp}, what);
  endtask

  task automatic pulse_clear();
    // Start spacing keeps the rate under 200 ksps
    repeat (200) @(negedge clk);
    @(negedge clk);
    complete_clear = 1'b1;
    @(negedge clk);
    complete_clear = 1'b0;
  endtask

  // Picks the overflow line that the timer's width calls for
  task automatic trigger(input logic [2:0] mode);
    @(negedge clk);
    case (mode)
      `SACC_MODE_SW: sw_start = 1'b1;
      `SACC_MODE_T0: begin src = 3'h0; fire = 1'b1; end
      `SACC_MODE_T1: begin src = 3'h1; fire = 1'b1; end
      `SACC_MODE_T2: begin src = split2 ? 3'h2 : 3'h3; fire = 1'b1; end
      `SACC_MODE_T3: begin src = split3 ? 3'h4 : 3'h5; fire = 1'b1; end
      default: pin = 1'b1;
    endcase
    @(negedge clk);
    sw_start = 1'b0;
    fire = 1'b0;
  endtask

  task automatic convert(input logic [2:0] mode, input logic [4:0] neg, input logic lj, input logic lp,
                         input logic [9:0] code);
    int n, d, hi;
    logic [15:0] exp;
    cfg.start_mode = mode;
    cfg.neg_sel = neg;
    cfg.left_justify = lj;
    cfg.low_power_track = lp;
    target = code;
    pin = 1'b0;
    pulse_clear();
    repeat (5) @(negedge clk);
    chk1(diff, neg != `SACC_NEG_GND, "diff mode");
    chk16({6'h00, pos_out, neg_out}, {6'h00, cfg.pos_sel, neg}, "mux select");
    chk1(track_en, !lp || mode == `SACC_MODE_PIN, "idle tracking");
    trigger(mode);
    n = 0;
    d = cfg.div + 1;
    hi = (10 + 3 * (lp && mode != `SACC_MODE_PIN)) * d + 1;
    while (!flag && n < 400) begin
      n += busy;
      if (busy && (!lp || mode == `SACC_MODE_PIN)) chk1(track_en, 1'b0, "track in conversion");
      @(negedge clk);
    end
    chk1(n >= hi - d - 4 && n <= hi, 1'b1, "busy length");
    chk1(flag, 1'b1, "complete flag");
    chk1(busy, 1'b0, "busy after end");
    chk1(irq, irq_enable, "interrupt");
    exp = lj ? {code, 6'h00} : (neg != `SACC_NEG_GND ? {{6{code[9]}}, code} : {6'h00, code});
    chk16({res_hi, res_lo}, exp, "result");
  endtask

  task automatic t_formats();
    logic [4:0] negs[8] = '{5'h1F, 5'h1F, 5'h1F, 5'h1F, 5'h1E, 5'h1E, 5'h00, 5'h05};
    logic       ljs[8]  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1};
    logic [9:0] codes[8] = '{10'h3FF, 10'h3FF, 10'h000, 10'h100, 10'h1FF, 10'h200, 10'h200, 10'h300};
    for (int i = 0; i < 8; i++) begin
      cfg.div = (i < 4) ? 5'h03 : 5'h09;
      cfg.pos_sel = 5'(i * 4 + 2);
      irq_enable = (i != 3);
      convert(`SACC_MODE_SW, negs[i], ljs[i], i[0], codes[i]);
    end
    irq_enable = 1'b1;
  endtask

  task automatic t_sources();
    logic [2:0] modes[8] = '{3'h1, 3'h3, 3'h2, 3'h2, 3'h5, 3'h5, 3'h4, 3'h4};
    for (int i = 0; i < 8; i++) begin
      split2 = i[0];
      split3 = i[0];
      convert(modes[i], 5'h1F, 1'b0, i[0], 10'(i * 100 + 7));
    end
  endtask

  // Overflow from the half that the timer's width does not use
  task automatic t_wrong_half();
    cfg.start_mode = `SACC_MODE_T2;
    split2 = 1'b1;
    @(negedge clk);
    src = 3'h3;
    fire = 1'b1;
    @(negedge clk);
    fire = 1'b0;
    repeat (3) @(negedge clk);
    chk1(busy, 1'b0, "ignored overflow");
    cfg.start_mode = 3'h6;
    trigger(`SACC_MODE_SW);
    repeat (3) @(negedge clk);
    chk1(busy, 1'b0, "unused mode");
  endtask

  task automatic t_overlap();
    int n;
    cfg.start_mode = `SACC_MODE_SW;
    cfg.low_power_track = 1'b0;
    pulse_clear();
    trigger(`SACC_MODE_SW);
    chk1(busy, 1'b1, "busy on start");
    repeat (20) @(negedge clk);
    trigger(`SACC_MODE_SW);
    n = 23;
    while (!flag && n < 400) begin
      n++;
      @(negedge clk);
    end
    chk1(n <= 10 * (cfg.div + 1) + 3, 1'b1, "no restart");
    repeat (4) @(negedge clk);
    chk1(busy, 1'b0, "stays idle");
  endtask

  task automatic t_disable();
    cfg.enable = 1'b0;
    pulse_clear();
    trigger(`SACC_MODE_SW);
    repeat (3) @(negedge clk);
    chk1(power_on, 1'b0, "powered down");
    chk1(busy, 1'b0, "no start when off");
    cfg.enable = 1'b1;
    trigger(`SACC_MODE_SW);
    repeat (8) @(negedge clk);
    cfg.enable = 1'b0;
    repeat (3) @(negedge clk);
    chk1(busy, 1'b0, "abort on disable");
    chk1(flag, 1'b1, "abort completes");
    cfg.enable = 1'b1;
  endtask

  task automatic print_verdict();
    $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    cfg.neg_sel = `SACC_NEG_GND;
    cfg.div = 5'h04;
    cfg.enable = 1'b1;
    repeat (16) @(negedge clk);
    rst = 1'b0;
    chk16({res_hi, res_lo}, 16'h0000, "reset result");
    chk1(flag, 1'b0, "reset flag");
    t_formats();
    t_sources();
    t_wrong_half();
    t_overlap();
    t_disable();
    print_verdict();
  end

  // About seven times the expected run length
  initial begin
    #(40000 * 25);
    n_mismatch++;
    print_verdict();
  end
endmodule
